// [verilog/wsm_cfg.svh]
`ifndef WSM_CFG_SVH
`define WSM_CFG_SVH

// device clock rate in Hz (250 MHz)
`define WSM_CLK_HZ      250000000

// function codes
`define WSM_FN_READ     8'h03
`define WSM_FN_WRITE    8'h06

// register offsets
`define WSM_REG_SPEED   16'h0000
`define WSM_REG_ADDR    16'h00A1
`define WSM_REG_BAUD    16'h00A2

// reset values
`define WSM_ADDR_RST    16'h0001
`define WSM_BAUD_RST    16'h0001

// frame layout
`define WSM_QTY_ONE     16'h0001
`define WSM_BYTE_CNT    8'h02
`define WSM_REQ_LEN     4'h8
`define WSM_RD_LEN      4'h7
`define WSM_IDX_OVER    4'h9
`define WSM_BUF_DEPTH   8

// crc16, reflected polynomial
`define WSM_CRC_INIT    16'hFFFF
`define WSM_CRC_POLY    16'hA001

// accepted write values
`define WSM_ADDR_MAX    16'h00F7
`define WSM_CODE_MAX    16'h0005

// bit rates in baud, per code 0..5
`define WSM_BAUD0       4800
`define WSM_BAUD1       9600
`define WSM_BAUD2       19200
`define WSM_BAUD3       38400
`define WSM_BAUD4       56000
`define WSM_BAUD5       115200

// idle gap: 3.5 characters of 10 bit times each
`define WSM_GAP_BITS    32'd35

`endif

// [verilog/wsm_pkg.sv]
package wsm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_CHECK, ST_LOAD, ST_SEND, ST_WAIT, ST_COMMIT
  } wsm_state_e;

  // request fields caught while the frame arrives
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] reg_addr;
    logic [15:0] value;
  } wsm_req_s;

endpackage

// [verilog/wsm_frame_buf.sv]
`timescale 1ns/1ps
`include "wsm_cfg.svh"

module wsm_frame_buf (
  input  wire logic       core_clk_i,
  input  wire logic       we_i,
  input  wire logic [2:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [2:0] raddr_i,
  output logic      [7:0] rdata_o
);

  logic [7:0] mem_q [`WSM_BUF_DEPTH];

  // write port, registered read port
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule

// [verilog/wsm_modbus_slave.sv]
`timescale 1ns/1ps
`include "wsm_cfg.svh"

module wsm_modbus_slave
  import wsm_pkg::*;
#(
  parameter int unsigned CLK_HZ_P = `WSM_CLK_HZ
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        line_i,
  input  wire logic [15:0] wind_speed_i,
  output logic             line_o,
  output logic             line_oe_n_o,
  output logic      [15:0] slave_addr_o,
  output logic      [15:0] bit_rate_code_o
);

  // one crc16 step over a byte, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `WSM_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // clock cycles per bit for a rate code
  function automatic logic [31:0] baud_div(input logic [15:0] code);
    logic [31:0] d;
    unique case (code)
      16'h0000: d = CLK_HZ_P / `WSM_BAUD0;
      16'h0002: d = CLK_HZ_P / `WSM_BAUD2;
      16'h0003: d = CLK_HZ_P / `WSM_BAUD3;
      16'h0004: d = CLK_HZ_P / `WSM_BAUD4;
      16'h0005: d = CLK_HZ_P / `WSM_BAUD5;
      default:  d = CLK_HZ_P / `WSM_BAUD1;
    endcase
    return d;
  endfunction

  wsm_state_e  state_q, state_d;
  wsm_req_s    req_q;
  logic [15:0] addr_q, code_q, crc_q, tcrc_q, speed_q;
  logic [31:0] div_q, gap_q, rx_cnt_q, tx_cnt_q;
  logic [3:0]  rx_bit_q, tx_bit_q, rx_idx_q, tx_idx_q;
  logic [7:0]  rx_sh_q;
  logic [9:0]  tx_sh_q;
  logic        rx_busy_q, rx_stb_q, bad_q, tx_busy_q, echo_q, line_q, oe_n_q;
  logic [7:0]  mem_rdata;

  // decode of the collected frame
  wire [31:0] gap_lim   = 32'(div_q * `WSM_GAP_BITS);
  wire        rx_en     = (state_q == ST_IDLE) || (state_q == ST_RX);
  wire        rx_tick   = rx_busy_q && (rx_cnt_q == 32'h0);
  wire        gap_end   = !rx_busy_q && line_i && (gap_q == gap_lim - 32'h1);
  wire        addr_hit  = ({8'h00, req_q.addr} == addr_q);
  wire        frame_ok  = (rx_idx_q == `WSM_REQ_LEN) && (crc_q == 16'h0000) && !bad_q && addr_hit;
  wire        is_read   = (req_q.func == `WSM_FN_READ) && (req_q.reg_addr == `WSM_REG_SPEED)
                          && (req_q.value == `WSM_QTY_ONE);
  wire        wr_addr   = (req_q.reg_addr == `WSM_REG_ADDR) && (req_q.value != 16'h0000)
                          && (req_q.value <= `WSM_ADDR_MAX);
  wire        wr_code   = (req_q.reg_addr == `WSM_REG_BAUD) && (req_q.value <= `WSM_CODE_MAX);
  wire        is_wr     = (req_q.func == `WSM_FN_WRITE) && (wr_addr || wr_code);
  wire        tx_done   = tx_busy_q && (tx_cnt_q == 32'h0) && (tx_bit_q == 4'h9);
  wire [3:0]  tx_len    = echo_q ? `WSM_REQ_LEN : `WSM_RD_LEN;
  wire        buf_we    = rx_stb_q && rx_en && (rx_idx_q < `WSM_REQ_LEN);

  // read reply bytes, data high byte first, crc low byte first
  wire [7:0]  rd_byte   = (tx_idx_q == 4'h0) ? addr_q[7:0]   :
                          (tx_idx_q == 4'h1) ? `WSM_FN_READ  :
                          (tx_idx_q == 4'h2) ? `WSM_BYTE_CNT :
                          (tx_idx_q == 4'h3) ? speed_q[15:8] :
                          (tx_idx_q == 4'h4) ? speed_q[7:0]  :
                          (tx_idx_q == 4'h5) ? tcrc_q[7:0]   :
                                               tcrc_q[15:8];
  wire [7:0]  tx_byte   = echo_q ? mem_rdata : rd_byte;

  // request bytes kept for the echo reply
  wsm_frame_buf u_buf (
    .core_clk_i (core_clk_i),
    .we_i       (buf_we),
    .waddr_i    (rx_idx_q[2:0]),
    .wdata_i    (rx_sh_q),
    .raddr_i    (tx_idx_q[2:0]),
    .rdata_o    (mem_rdata)
  );

  // frame sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (rx_stb_q) state_d = ST_RX;
      ST_RX:     if (gap_end) state_d = ST_CHECK;
      ST_CHECK:  state_d = (frame_ok && (is_read || is_wr)) ? ST_LOAD : ST_IDLE;
      ST_LOAD:   state_d = ST_SEND;
      ST_SEND:   state_d = ST_WAIT;
      ST_WAIT:   if (tx_done) state_d = (tx_idx_q == tx_len - 4'h1) ? ST_COMMIT : ST_LOAD;
      ST_COMMIT: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) state_q <= ST_IDLE;
    else            state_q <= state_d;
  end

  // register file: address and rate code apply once the echo is out
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      addr_q <= `WSM_ADDR_RST;
      code_q <= `WSM_BAUD_RST;
      div_q  <= CLK_HZ_P / `WSM_BAUD1;
    end else begin
      div_q <= baud_div(code_q);
      if (state_q == ST_COMMIT && echo_q && wr_addr) addr_q <= req_q.value;
      if (state_q == ST_COMMIT && echo_q && wr_code) code_q <= req_q.value;
    end
  end

  // receiver: sample mid bit, 8N1
  always_ff @(posedge core_clk_i) begin
    rx_stb_q <= 1'b0;
    if (!reset_n_i) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 32'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
    end else if (!rx_busy_q) begin
      if (!line_i && rx_en) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= div_q >> 1;
        rx_bit_q  <= 4'h0;
      end
    end else if (rx_cnt_q != 32'h0) begin
      rx_cnt_q <= rx_cnt_q - 32'h1;
    end else begin
      rx_cnt_q <= div_q - 32'h1;
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && line_i) rx_busy_q <= 1'b0;       // glitch, not a start bit
      if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9) rx_sh_q <= {line_i, rx_sh_q[7:1]};
      if (rx_bit_q == 4'h9) begin
        rx_busy_q <= 1'b0;
        rx_stb_q  <= 1'b1;
      end
    end
  end

  // idle gap timer, held at zero while a character is on the line
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || rx_busy_q || !line_i) gap_q <= 32'h0;
    else if (gap_q < gap_lim)               gap_q <= gap_q + 32'h1;
  end

  // frame collection: crc, field capture, length and framing faults
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || state_q == ST_CHECK) begin
      crc_q    <= `WSM_CRC_INIT;
      rx_idx_q <= 4'h0;
      bad_q    <= 1'b0;
    end else begin
      if (rx_tick && rx_bit_q == 4'h9 && !line_i && rx_en) bad_q <= 1'b1;
      if (rx_stb_q && rx_en) begin
        crc_q <= crc_byte(crc_q, rx_sh_q);
        if (rx_idx_q != `WSM_IDX_OVER) rx_idx_q <= rx_idx_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_q <= '0;
    end else if (buf_we) begin
      unique case (rx_idx_q)
        4'h0:    req_q.addr            <= rx_sh_q;
        4'h1:    req_q.func            <= rx_sh_q;
        4'h2:    req_q.reg_addr[15:8]  <= rx_sh_q;
        4'h3:    req_q.reg_addr[7:0]   <= rx_sh_q;
        4'h4:    req_q.value[15:8]     <= rx_sh_q;
        4'h5:    req_q.value[7:0]      <= rx_sh_q;
        default: req_q.addr            <= req_q.addr;
      endcase
    end
  end

  // reply setup: reply kind, speed snapshot, outgoing crc
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      echo_q   <= 1'b0;
      speed_q  <= 16'h0000;
      tcrc_q   <= `WSM_CRC_INIT;
      tx_idx_q <= 4'h0;
    end else if (state_q == ST_CHECK) begin
      echo_q   <= !is_read;
      speed_q  <= wind_speed_i;
      tcrc_q   <= `WSM_CRC_INIT;
      tx_idx_q <= 4'h0;
    end else begin
      if (state_q == ST_SEND && tx_idx_q < 4'h5) tcrc_q <= crc_byte(tcrc_q, tx_byte);
      if (state_q == ST_WAIT && tx_done) tx_idx_q <= tx_idx_q + 4'h1;
    end
  end

  // transmitter: start bit, 8 data lsb first, stop bit
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 32'h0;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
      line_q    <= 1'b1;
    end else if (state_q == ST_SEND) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q  <= div_q - 32'h1;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= {1'b1, tx_byte, 1'b0};
      line_q    <= 1'b0;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != 32'h0) begin
        tx_cnt_q <= tx_cnt_q - 32'h1;
      end else begin
        tx_cnt_q  <= div_q - 32'h1;
        tx_bit_q  <= tx_bit_q + 4'h1;
        tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
        line_q    <= (tx_bit_q == 4'h9) ? 1'b1 : tx_sh_q[1];
        tx_busy_q <= (tx_bit_q != 4'h9);
      end
    end
  end

  // driver enable, low across the whole reply
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) oe_n_q <= 1'b1;
    else oe_n_q <= !(state_d == ST_LOAD || state_d == ST_SEND || state_d == ST_WAIT);
  end

  assign line_o          = line_q;
  assign line_oe_n_o     = oe_n_q;
  assign slave_addr_o    = addr_q;
  assign bit_rate_code_o = code_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_good_write;
    state_q == ST_CHECK && frame_ok && is_wr && !is_read;
  endsequence
  sequence s_good_read;
    state_q == ST_CHECK && frame_ok && is_read;
  endsequence

  a_reset_addr: assert property ($rose(reset_n_i) |-> slave_addr_o == `WSM_ADDR_RST)
    else $error("address not one after reset");
  a_reset_rate: assert property ($rose(reset_n_i) |->
      bit_rate_code_o == `WSM_BAUD_RST ##1 div_q == CLK_HZ_P / `WSM_BAUD1)
    else $error("default bit rate not 9600");
  a_crc_low_first: assert property (state_q == ST_SEND && !echo_q && tx_idx_q == 4'h5
      |-> tx_byte == tcrc_q[7:0]) else $error("reply crc low byte not first");
  a_crc_high_last: assert property (state_q == ST_SEND && !echo_q && tx_idx_q == 4'h6
      |-> tx_byte == tcrc_q[15:8]) else $error("reply crc high byte not last");
  a_data_high_first: assert property (state_q == ST_SEND && !echo_q && tx_idx_q == 4'h3
      |-> tx_byte == speed_q[15:8]) else $error("speed high byte not first");
  a_read_request: assert property (s_good_read |=> state_q == ST_LOAD && !echo_q
      && speed_q == $past(wind_speed_i) && req_q.reg_addr == `WSM_REG_SPEED)
    else $error("read reply not started for speed");
  a_read_count: assert property (state_q == ST_SEND && !echo_q && tx_idx_q == 4'h2
      |-> tx_byte == `WSM_BYTE_CNT && tx_len == `WSM_RD_LEN) else $error("read count wrong");
  a_addr_commit: assert property ($changed(slave_addr_o) |->
      $past(state_q) == ST_COMMIT && slave_addr_o == $past(req_q.value))
    else $error("address changed outside commit");
  a_rate_decode: assert property ($changed(bit_rate_code_o) |=>
      div_q == baud_div(bit_rate_code_o)) else $error("bit rate divider not updated");
  a_echo_start: assert property (s_good_write |=> state_q == ST_LOAD && echo_q
      ##1 state_q == ST_SEND && tx_byte == mem_rdata) else $error("write not echoed");
  a_drop_frame: assert property (state_q == ST_CHECK && !frame_ok |=>
      state_q == ST_IDLE && line_oe_n_o) else $error("bad frame answered");
  a_gap_end: assert property (state_q == ST_RX ##1 state_q == ST_CHECK |->
      $past(gap_q) == gap_lim - 32'h1) else $error("frame closed before idle gap");

endmodule

// [tb/wsm_master_model.sv]
`timescale 1ns/1ps

// bus master: sends request frames, collects reply characters
module wsm_master_model (
  input  wire logic core_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  int div = 50;

  initial line_o = 1'b1;

  // one character: start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o = sh[i];
      repeat (div) @(negedge core_clk_i);
    end
  endtask

  // request of six bytes, crc low byte then high byte
  task automatic send_frame(input logic [47:0] body, input logic [15:0] crc);
    @(negedge core_clk_i);
    // idle gap of 3.5 characters before every request
    repeat (35 * div) @(negedge core_clk_i);
    for (int i = 0; i < 6; i++) send_byte(body[47 - 8 * i -: 8]);
    send_byte(crc[7:0]);
    send_byte(crc[15:8]);
  endtask

  // mid-bit sampling; ok means a start came and the stop was high
  task automatic recv_byte(input int lim, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line_i !== 1'b0 && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
    if (line_i === 1'b0) begin
      repeat (div + div / 2) @(negedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
        b[i] = line_i;
        repeat (div) @(negedge core_clk_i);
      end
      ok = (line_i === 1'b1);
    end
  endtask
endmodule

// [tb/test_wind_speed_modbus_slave.sv]
`timescale 1ns/1ps

module test_wind_speed_modbus_slave;
  localparam int unsigned CLK_HZ = 480000;
  logic        core_clk_i;
  logic        reset_n_i;
  logic        mst_tx;
  logic        line_o;
  logic        line_oe_n_o;
  logic [15:0] wind_speed_i;
  logic [15:0] slave_addr_o;
  logic [15:0] bit_rate_code_o;
  logic [31:0] rng;
  int          error_cnt;
  int          compares;
  wire         line = line_oe_n_o ? mst_tx : line_o;

  wsm_modbus_slave #(.CLK_HZ_P(CLK_HZ)) uut (
    .core_clk_i     (core_clk_i),
    .reset_n_i      (reset_n_i),
    .line_i         (line),
    .wind_speed_i   (wind_speed_i),
    .line_o         (line_o),
    .line_oe_n_o    (line_oe_n_o),
    .slave_addr_o   (slave_addr_o),
    .bit_rate_code_o(bit_rate_code_o)
  );

  wsm_master_model mst (
    .core_clk_i(core_clk_i),
    .line_i    (line),
    .line_o    (mst_tx)
  );

  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // crc16 over the first n bytes, reflected polynomial
  function automatic logic [15:0] crc16(input logic [47:0] d, input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c ^= {8'h00, d[47 - 8 * i -: 8]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // bit rate in baud for a rate code
  function automatic int baud(input int code);
    int t [6];
    t = '{4800, 9600, 19200, 38400, 56000, 115200};
    return t[code];
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one request and its reply of n bytes (0 means none)
  task automatic xfer(input string what, input logic [47:0] body, input logic [15:0] crc,
                      input int n, input logic [63:0] exp);
    logic [7:0] b;
    logic       ok;
    int         k;
    mst.send_frame(body, crc);
    mst.recv_byte(40 * mst.div, b, ok);
    if (n == 0) check({what, " reply"}, {15'h0, ok}, 16'h0000);
    for (int i = 0; i < n; i++) begin
      if (i > 0) mst.recv_byte(4 * mst.div, b, ok);
      check({what, " byte"}, {8'h00, b}, {8'h00, exp[63 - 8 * i -: 8]});
      check({what, " stop"}, {15'h0, ok}, 16'h0001);
    end
    k = 0;
    while (line_oe_n_o !== 1'b1 && k < 4 * mst.div) begin
      @(negedge core_clk_i);
      k++;
    end
    check({what, " release"}, {15'h0, line_oe_n_o}, 16'h0001);
    repeat (4) @(negedge core_clk_i);
    $display("done %s", what);
  endtask

  // speed read; flip spoils the crc, n is the reply length
  task automatic rd(input string what, input logic [7:0] a, input logic [15:0] flip,
                    input int n);
    logic [47:0] q;
    logic [15:0] c;
    rng = xs(rng);
    wind_speed_i = rng[15:0];
    q = {a, 8'h03, 16'h0000, 16'h0001};
    c = crc16({a, 8'h03, 8'h02, rng[15:0], 8'h00}, 5);
    xfer(what, q, crc16(q, 6) ^ flip, n, {a, 8'h03, 8'h02, rng[15:0], c[7:0], c[15:8], 8'h00});
  endtask

  // single register write; echoed when n is 8
  task automatic wr(input string what, input logic [7:0] a, input logic [15:0] r,
                    input logic [15:0] v, input int n);
    logic [47:0] q;
    logic [15:0] c;
    q = {a, 8'h06, r, v};
    c = crc16(q, 6);
    xfer(what, q, c, n, {q, c[7:0], c[15:8]});
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  initial begin
    logic [7:0] na;
    rng = 32'd45;
    error_cnt = 0;
    compares = 0;
    reset_n_i = 1'b0;
    wind_speed_i = 16'h0602;
    repeat (8) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    check("addr reset", slave_addr_o, 16'h0001);
    check("rate reset", bit_rate_code_o, 16'h0001);
    rd("read default", 8'h01, 16'h0000, 7);
    rd("bad crc", 8'h01, 16'h0100, 0);
    rng = xs(rng);
    na = 8'(rng % 246) + 8'h02;
    wr("new address", 8'h01, 16'h00A1, {8'h00, na}, 8);
    check("address", slave_addr_o, {8'h00, na});
    rd("old address", 8'h01, 16'h0000, 0);
    wr("new rate", na, 16'h00A2, 16'h0002, 8);
    check("rate", bit_rate_code_o, 16'h0002);
    mst.div = int'(CLK_HZ / 19200);
    rd("read fast", na, 16'h0000, 7);
    wr("bad code", na, 16'h00A2, 16'h0007, 0);
    check("rate kept", bit_rate_code_o, 16'h0002);
    // step through the faster rate codes, reading at each
    for (int r = 3; r < 6; r++) begin
      wr("rate step", na, 16'h00A2, 16'(r), 8);
      check("rate step", bit_rate_code_o, 16'(r));
      mst.div = int'(CLK_HZ) / baud(r);
      rd("read step", na, 16'h0000, 7);
    end
    summarize();
  end
endmodule
